// [rtl/i2c_dma_irq_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - transmit or receive flag with its dma enable raises a dma request
// - transmit dma request only while bit 14 is one
// - receive dma request only while bit 15 is one
// - six error flags; checksum mismatch when received crc differs
// - each event flag gated by its enable; done and reload share one
// - stop in slave mode sets stop flag, interrupts when enabled
// - debug halt freezes stall counter when hold select is set
// - main control at 0x00, resets to zero, word access only
// - bit 23 turns checksum calculation on
// - bit 22 drives alert low as device, enables sensing as host
// - bit 21 acknowledges the smbus device default address
// - bit 20 acknowledges the smbus host address
// - bit 19 enables response to general call
// - two instances, bases 0x40005400 and 0x40005800
// - error enable lets any error flag raise the error interrupt
// - digital filter rejects spikes up to n clock periods
module i2c_dma_irq_control #(
  parameter logic [31:0] BASE_ADDR    = i2c_ctl_pkg::BASE_UNIT0,
  parameter int          STALL_LIMIT  = i2c_ctl_pkg::STALL_CYCLES
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  input  wire logic        ALERT_PIN_IN,
  output logic             ALERT_PIN_OUT,
  output logic             ALERT_PIN_OE_OUT,
  input  wire logic        SLAVE_MODE_IN,
  input  wire logic        TRANSMIT_SET_IN,
  input  wire logic        RECEIVE_FULL_SET_IN,
  input  wire logic        TX_DATA_WRITTEN_IN,
  input  wire logic        RX_DATA_READ_IN,
  input  wire logic        ADDRESS_MATCH_SET_IN,
  input  wire logic        NOT_ACK_SET_IN,
  input  wire logic        TRANSFER_DONE_SET_IN,
  input  wire logic        TRANSFER_RELOAD_SET_IN,
  input  wire logic        BUS_FAULT_SET_IN,
  input  wire logic        ARBITRATION_LOST_SET_IN,
  input  wire logic        OVER_UNDER_SET_IN,
  input  wire logic        CRC_CLEAR_IN,
  input  wire logic        CRC_BYTE_VALID_IN,
  input  wire logic        PEC_BYTE_VALID_IN,
  input  wire logic [7:0]  CRC_BYTE_IN,
  input  wire logic [7:0]  ADDR_BYTE_IN,
  output logic             ADDR_ACK_OUT,
  input  wire logic        DEBUG_HALT_IN,
  input  wire logic        DEBUG_HOLD_SELECT_IN,
  output logic             DMA_TX_REQ_OUT,
  output logic             DMA_RX_REQ_OUT,
  output logic             EVENT_IRQ_OUT,
  output logic             ERROR_IRQ_OUT,
  output logic             SCL_FILTERED_OUT,
  output logic             SDA_FILTERED_OUT,
  output logic      [31:0] MAIN_CONTROL_OUT
);

  //////////////////////////////////////////////////////////////////
  // registers and wires
  logic [31:0] main_control;
  logic [13:0] flags;
  logic [31:0] rdata;
  logic        wr_pend;
  logic        wr_word;
  logic [11:0] wr_ofs;
  logic [1:0]  line_f;
  logic        scl_prev;
  logic        sda_prev;
  logic        alert_meta;
  logic        alert_sync;
  logic        alert_prev;
  logic [31:0] stall_cnt;
  logic        stall_hit;
  logic [7:0]  crc_value;

  // control fields
  wire logic       periph_en      = main_control[i2c_ctl_pkg::PERIPHERAL_ENABLE_B];
  wire logic       dma_tx_enable  = main_control[i2c_ctl_pkg::DMA_TX_ENABLE_B];
  wire logic       dma_rx_enable  = main_control[i2c_ctl_pkg::DMA_RX_ENABLE_B];
  wire logic       error_irq_en   = main_control[i2c_ctl_pkg::ERROR_IRQ_ENABLE_B];
  wire logic       gc_en          = main_control[i2c_ctl_pkg::GENERAL_CALL_ENABLE_B];
  wire logic       host_addr_en   = main_control[i2c_ctl_pkg::HOST_ADDRESS_ENABLE_B];
  wire logic       dflt_addr_en   = main_control[i2c_ctl_pkg::DEFAULT_ADDRESS_ENABLE_B];
  wire logic       alert_enable   = main_control[i2c_ctl_pkg::ALERT_ENABLE_B];
  wire logic       checksum_en    = main_control[i2c_ctl_pkg::CHECKSUM_CALC_ENABLE_B];
  wire logic [3:0] filter_len     = main_control[i2c_ctl_pkg::DIGITAL_FILTER_LO +: 4];

  //////////////////////////////////////////////////////////////////
  // ahb-lite slave: decode, zero wait states, always okay
  wire logic        in_window = (HADDR_IN[31:10] == BASE_ADDR[31:10]);
  wire logic        addr_phase = HSEL_IN && HTRANS_IN[1] && HREADY_IN && in_window;
  wire logic [11:0] ofs = {2'h0, HADDR_IN[9:0]};
  wire logic        is_word = (HSIZE_IN == i2c_ctl_pkg::HSIZE_WORD);
  // registered write phase: the data arrive one cycle after the address
  wire logic        wr_ctrl = wr_pend && wr_word && (wr_ofs == i2c_ctl_pkg::MAIN_CONTROL_OFS);
  wire logic        wr_clr  = wr_pend && wr_word && (wr_ofs == i2c_ctl_pkg::FLAG_CLEAR_OFS);
  // read mux; reserved and unmapped places read zero
  wire logic [31:0] rd_value =
      (ofs == i2c_ctl_pkg::MAIN_CONTROL_OFS) ? main_control :
      (ofs == i2c_ctl_pkg::FLAG_STATUS_OFS)  ? {18'h0, flags} : 32'h0000_0000;

  // zero wait states; the slave never answers with an error
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = rdata;

  // capture the address phase; read data registered for the data phase
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      wr_pend <= 1'b0;
      wr_word <= 1'b0;
      wr_ofs  <= 12'h000;
      rdata   <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase && HWRITE_IN;
      wr_word <= is_word;
      wr_ofs  <= ofs;
      if (addr_phase && !HWRITE_IN) begin
        rdata <= is_word ? rd_value : 32'h0000_0000;
      end
    end
  end

  // main control; reserved bits never stored
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      main_control <= i2c_ctl_pkg::MAIN_CONTROL_RST;
    end else if (wr_ctrl) begin
      main_control <= HWDATA_IN & i2c_ctl_pkg::MAIN_CONTROL_WM;
    end
  end
  assign MAIN_CONTROL_OUT = main_control;

  //////////////////////////////////////////////////////////////////
  // line filters and bus condition detection
  i2c_line_filter u_filter (
    .clk_in    (REF_CLK_IN),
    .rst_in    (RST_IN),
    .line_in   ({SDA_IN, SCL_IN}),
    .length_in (filter_len),
    .line_out  (line_f)
  );
  // filtered lines for the transfer logic
  assign SCL_FILTERED_OUT = line_f[0];
  assign SDA_FILTERED_OUT = line_f[1];

  // stop: filtered data rises while the filtered clock stays high
  wire logic stop_seen = line_f[0] && scl_prev && line_f[1] && !sda_prev;
  // alert: the synchronised pin falls
  wire logic alert_fall = alert_prev && !alert_sync;

  // previous filtered levels, alert pin synchroniser
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      scl_prev   <= 1'b1;
      sda_prev   <= 1'b1;
      alert_meta <= 1'b1;
      alert_sync <= 1'b1;
      alert_prev <= 1'b1;
    end else begin
      scl_prev   <= line_f[0];
      sda_prev   <= line_f[1];
      alert_meta <= ALERT_PIN_IN;
      alert_sync <= alert_meta;
      alert_prev <= alert_sync;
    end
  end

  //////////////////////////////////////////////////////////////////
  // checksum over the message and compare on the received code byte
  i2c_crc8 u_crc (
    .clk_in        (REF_CLK_IN),
    .rst_in        (RST_IN),
    .clear_in      (CRC_CLEAR_IN || !checksum_en),
    .byte_valid_in (CRC_BYTE_VALID_IN && checksum_en),
    .byte_in       (CRC_BYTE_IN),
    .crc_out       (crc_value)
  );
  // a mismatch counts only while the checksum is switched on
  wire logic crc_bad = PEC_BYTE_VALID_IN && checksum_en && (CRC_BYTE_IN != crc_value);

  //////////////////////////////////////////////////////////////////
  // bus stall counter: runs while scl is held low
  wire logic stall_freeze = DEBUG_HALT_IN && DEBUG_HOLD_SELECT_IN;
  wire logic scl_low      = periph_en && !line_f[0];

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN || !scl_low) begin
      stall_cnt <= 32'h0000_0000;
      stall_hit <= 1'b0;
    end else if (!stall_freeze) begin
      if (stall_cnt == 32'(STALL_LIMIT - 1)) begin
        stall_hit <= 1'b1;
      end else begin
        stall_cnt <= stall_cnt + 32'h0000_0001;
      end
    end
  end
  // flag pulse in the one cycle in which the count reaches the limit
  wire logic stall_set = scl_low && !stall_freeze && !stall_hit &&
                         (stall_cnt == 32'(STALL_LIMIT - 1));

  //////////////////////////////////////////////////////////////////
  // sticky flags: a set in the clearing cycle wins
  wire logic [13:0] set_vec = {14{periph_en}} & {
    alert_fall && alert_enable && host_addr_en,
    stall_set,
    crc_bad,
    OVER_UNDER_SET_IN,
    ARBITRATION_LOST_SET_IN,
    BUS_FAULT_SET_IN,
    1'b0,
    TRANSFER_RELOAD_SET_IN,
    TRANSFER_DONE_SET_IN,
    stop_seen && SLAVE_MODE_IN,
    NOT_ACK_SET_IN,
    ADDRESS_MATCH_SET_IN,
    RECEIVE_FULL_SET_IN,
    TRANSMIT_SET_IN
  };

  // software clear of bits 13:2, data access pulses for bits 1:0
  wire logic [13:0] clr_vec =
      ({14{wr_clr}} & HWDATA_IN[13:0] & i2c_ctl_pkg::FLAG_SW_CLR_MASK) |
      {12'h000, RX_DATA_READ_IN, TX_DATA_WRITTEN_IN};

  // one flop per flag, so a set beats a clear that arrives with it
  for (genvar f = 0; f < 14; f++) begin : g_flag
    always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
        flags[f] <= 1'b0;
      end else begin
        flags[f] <= set_vec[f] || (flags[f] && !clr_vec[f]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // interrupt and dma gating
  wire logic [6:0] event_en = {
    main_control[i2c_ctl_pkg::TRANSFER_DONE_IRQ_EN_B],
    main_control[i2c_ctl_pkg::TRANSFER_DONE_IRQ_EN_B],
    main_control[i2c_ctl_pkg::STOP_DETECT_IRQ_EN_B],
    main_control[i2c_ctl_pkg::NOT_ACK_IRQ_ENABLE_B],
    main_control[i2c_ctl_pkg::ADDRESS_MATCH_IRQ_EN_B],
    main_control[i2c_ctl_pkg::RECEIVE_IRQ_ENABLE_B],
    main_control[i2c_ctl_pkg::TRANSMIT_IRQ_ENABLE_B]
  };
  wire logic next_event_irq = |(flags[6:0] & event_en);
  wire logic next_error_irq = error_irq_en && |flags[13:8];
  // dma requests follow their flag only while enabled
  wire logic next_dma_tx = dma_tx_enable && flags[i2c_ctl_pkg::TRANSMIT_F];
  wire logic next_dma_rx = dma_rx_enable && flags[i2c_ctl_pkg::RECEIVE_F];

  //////////////////////////////////////////////////////////////////
  // smbus special address acknowledge
  wire logic [6:0] addr7 = ADDR_BYTE_IN[7:1];
  wire logic next_addr_ack =
      (dflt_addr_en && addr7 == i2c_ctl_pkg::DEFAULT_ADDR) ||
      (host_addr_en && addr7 == i2c_ctl_pkg::HOST_ADDR) ||
      (gc_en && addr7 == i2c_ctl_pkg::GENERAL_CALL_ADDR) ||
      (alert_enable && !host_addr_en && addr7 == i2c_ctl_pkg::ALERT_RESP_ADDR);

  // registered outputs
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      EVENT_IRQ_OUT    <= 1'b0;
      ERROR_IRQ_OUT    <= 1'b0;
      DMA_TX_REQ_OUT   <= 1'b0;
      DMA_RX_REQ_OUT   <= 1'b0;
      ADDR_ACK_OUT     <= 1'b0;
      ALERT_PIN_OE_OUT <= 1'b0;
    end else begin
      EVENT_IRQ_OUT    <= next_event_irq;
      ERROR_IRQ_OUT    <= next_error_irq;
      DMA_TX_REQ_OUT   <= next_dma_tx;
      DMA_RX_REQ_OUT   <= next_dma_rx;
      ADDR_ACK_OUT     <= next_addr_ack;
      ALERT_PIN_OE_OUT <= alert_enable && !host_addr_en;
    end
  end

  // open drain pin: the enable pulls the line low, it is never driven high
  assign ALERT_PIN_OUT = 1'b0; // open drain, only ever pulls low

endmodule
`default_nettype wire

// [rtl/i2c_ctl_pkg.sv]
`default_nettype none
package i2c_ctl_pkg;
  // register offsets inside one instance window
  localparam logic [11:0] MAIN_CONTROL_OFS = 12'h000;
  localparam logic [11:0] FLAG_STATUS_OFS  = 12'h004;
  localparam logic [11:0] FLAG_CLEAR_OFS   = 12'h008;
  localparam logic [31:0] BASE_UNIT0       = 32'h4000_5400;
  localparam logic [31:0] BASE_UNIT1       = 32'h4000_5800;
  localparam logic [31:0] MAIN_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] MAIN_CONTROL_WM  = 32'h00FB_DFFF;
  localparam logic [13:0] FLAG_SW_CLR_MASK = 14'h3FFC;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
  // main_control field positions
  localparam int PERIPHERAL_ENABLE_B      = 0;
  localparam int TRANSMIT_IRQ_ENABLE_B    = 1;
  localparam int RECEIVE_IRQ_ENABLE_B     = 2;
  localparam int ADDRESS_MATCH_IRQ_EN_B   = 3;
  localparam int NOT_ACK_IRQ_ENABLE_B     = 4;
  localparam int STOP_DETECT_IRQ_EN_B     = 5;
  localparam int TRANSFER_DONE_IRQ_EN_B   = 6;
  localparam int ERROR_IRQ_ENABLE_B       = 7;
  localparam int DIGITAL_FILTER_LO        = 8;
  localparam int DMA_TX_ENABLE_B          = 14;
  localparam int DMA_RX_ENABLE_B          = 15;
  localparam int GENERAL_CALL_ENABLE_B    = 19;
  localparam int HOST_ADDRESS_ENABLE_B    = 20;
  localparam int DEFAULT_ADDRESS_ENABLE_B = 21;
  localparam int ALERT_ENABLE_B           = 22;
  localparam int CHECKSUM_CALC_ENABLE_B   = 23;
  // flag positions in the status word
  localparam int TRANSMIT_F = 0;
  localparam int RECEIVE_F  = 1;
  localparam int ADDRESS_F  = 2;
  localparam int NOT_ACK_F  = 3;
  localparam int STOP_F     = 4;
  localparam int DONE_F     = 5;
  localparam int RELOAD_F   = 6;
  localparam int ERROR_LO_F = 8;
  // smbus special addresses, seven bit
  localparam logic [6:0] DEFAULT_ADDR   = 7'h61;
  localparam logic [6:0] HOST_ADDR      = 7'h08;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [7:0] CRC_POLY       = 8'h07;
  localparam logic [7:0] CRC_INIT       = 8'h00;
  // bus stall limit
  localparam longint STALL_TIME_NS = 25000000;
  localparam longint CLK_PERIOD_NS = 20;
  localparam int     STALL_CYCLES  = int'(STALL_TIME_NS / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// [rtl/i2c_crc8.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_crc8 (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       clear_in,
  input  wire logic       byte_valid_in,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] crc_out
);
  //////////////////////////////////////////////////////////////////
  // one byte of crc-8, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ i2c_ctl_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  wire logic [7:0] next_crc = crc_step(crc_out, byte_in);

  // running checksum over the message
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      crc_out <= i2c_ctl_pkg::CRC_INIT;
    end else if (byte_valid_in) begin
      crc_out <= next_crc;
    end
  end
endmodule
`default_nettype wire

// [rtl/i2c_line_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_line_filter (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] line_in,
  input  wire logic [3:0] length_in,
  output logic      [1:0] line_out
);
  //////////////////////////////////////////////////////////////////
  // per line: two-stage sync, then spike rejection up to length cycles
  for (genvar g = 0; g < 2; g++) begin : g_line
    logic       meta;
    logic       sync;
    logic [3:0] cnt;
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        meta        <= 1'b1;
        sync        <= 1'b1;
        cnt         <= 4'h0;
        line_out[g] <= 1'b1;
      end else begin
        meta <= line_in[g];
        sync <= meta;
        if (sync == line_out[g]) begin
          cnt <= 4'h0;
        end else if (cnt >= length_in) begin
          line_out[g] <= sync;
          cnt         <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/i2c_dma_irq_control_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_dma_irq_control_chk (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_IN,
  input wire logic [31:0] MAIN_CONTROL_OUT,
  input wire logic        TRANSMIT_SET_IN,
  input wire logic        BUS_FAULT_SET_IN,
  input wire logic        NOT_ACK_SET_IN,
  input wire logic [7:0]  ADDR_BYTE_IN,
  input wire logic        ADDR_ACK_OUT,
  input wire logic        DMA_TX_REQ_OUT,
  input wire logic        DMA_RX_REQ_OUT,
  input wire logic        EVENT_IRQ_OUT,
  input wire logic        ERROR_IRQ_OUT,
  input wire logic        ALERT_PIN_OE_OUT
);
  wire logic [31:0] mc;
  // short alias for the control word
  assign mc = MAIN_CONTROL_OUT;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////////
  // the transmit request follows an enabled flag two cycles on; both requests only while enabled
  AST_TX_REQ: assert property (
    (TRANSMIT_SET_IN && mc[0] && mc[14]) ##1 mc[14] |-> ##1 DMA_TX_REQ_OUT)
    else $error("transmit request missing");
  AST_TX_GATE: assert property (!$past(mc[14]) |-> !DMA_TX_REQ_OUT)
    else $error("transmit request while disabled");
  AST_RX_GATE: assert property (!$past(mc[15]) |-> !DMA_RX_REQ_OUT)
    else $error("receive request while disabled");
  // special addresses are answered one cycle later, per enable bit
  AST_DEF_ACK: assert property (
    ADDR_BYTE_IN[7:1] == 7'h61 |=> ADDR_ACK_OUT == $past(mc[21]))
    else $error("default address answer wrong");
  AST_HOST_ACK: assert property (
    ADDR_BYTE_IN[7:1] == 7'h08 |=> ADDR_ACK_OUT == $past(mc[20]))
    else $error("host address answer wrong");
  AST_GC_ACK: assert property (
    ADDR_BYTE_IN == 8'h00 |=> ADDR_ACK_OUT == $past(mc[19]))
    else $error("general call answer wrong");
  // enabled flags reach the interrupt lines two cycles on
  AST_ERR_IRQ: assert property (
    (BUS_FAULT_SET_IN && mc[0] && mc[7]) ##1 mc[7] |-> ##1 ERROR_IRQ_OUT)
    else $error("error interrupt missing");
  AST_EVT_IRQ: assert property (
    (NOT_ACK_SET_IN && mc[0] && mc[4]) ##1 mc[4] |-> ##1 EVENT_IRQ_OUT)
    else $error("event interrupt missing");
  AST_ALERT_OE: assert property (
    ALERT_PIN_OE_OUT == ($past(mc[22]) && !$past(mc[20])))
    else $error("alert pull wrong");
  // main scenarios reached
  cover property (DMA_RX_REQ_OUT);
  cover property (EVENT_IRQ_OUT);
  cover property (ERROR_IRQ_OUT);
endmodule
bind i2c_dma_irq_control i2c_dma_irq_control_chk CHK (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .MAIN_CONTROL_OUT(MAIN_CONTROL_OUT),
  .TRANSMIT_SET_IN(TRANSMIT_SET_IN), .BUS_FAULT_SET_IN(BUS_FAULT_SET_IN),
  .NOT_ACK_SET_IN(NOT_ACK_SET_IN), .ADDR_BYTE_IN(ADDR_BYTE_IN), .ADDR_ACK_OUT(ADDR_ACK_OUT),
  .DMA_TX_REQ_OUT(DMA_TX_REQ_OUT), .DMA_RX_REQ_OUT(DMA_RX_REQ_OUT),
  .EVENT_IRQ_OUT(EVENT_IRQ_OUT), .ERROR_IRQ_OUT(ERROR_IRQ_OUT),
  .ALERT_PIN_OE_OUT(ALERT_PIN_OE_OUT)
);
`default_nettype wire

// [sim/i2c_remote_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_remote_model (
  output logic scl_out,
  output logic sda_out,
  output logic alert_out
);
  // lines are pulled up, so released means high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    alert_out = 1'b1;
  end
  // start, eight zero bits and an acknowledge on a 160 ns clock, then stop; clock idles high
  task automatic frame();
    #5 sda_out = 1'b0;
    #80;
    repeat (9) begin
      scl_out = 1'b0;
      #80 scl_out = 1'b1;
      #80;
    end
    sda_out = 1'b1;
    #160;
  endtask
  // short low spike on data while clock is high
  task automatic glitch();
    #5 sda_out = 1'b0;
    #30 sda_out = 1'b1;
  endtask
  // remote alert pull, open drain
  task automatic alert(input logic low);
    alert_out = ~low;
  endtask
  // hold the clock line low, as a stretching device would
  task automatic scl_hold(input logic low);
    scl_out = ~low;
  endtask
endmodule
`default_nettype wire

// [sim/i2c_dma_irq_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_dma_irq_control_tb_top;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [8:0]  ev;
    logic [3:0]  exp;
  } row_t;
  localparam logic [31:0] BASE = i2c_ctl_pkg::BASE_UNIT1;
  logic              clk, rst, hsel, hwrite, tx_wr, rx_rd, crc_clr, crc_v, pec_v;
  logic              slave, dhalt, dhold;
  logic [31:0]       haddr, hwdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [8:0]        ev;
  logic [7:0]        crc_b, addr_b;
  logic [6:0]        sa [3];
  wire logic [31:0]  hrdata, mc;
  wire logic         hready, hresp, scl, sda, alert_n, alert_o, oe, ack;
  wire logic         tx_req, rx_req, evt, err, sclf, sdaf;
  wire logic [3:0]   outs = {tx_req, rx_req, evt, err};
  int                n_mismatch, n_compared, cyc, i;
  row_t              rows [15];
  ////////////////////////////////////////////////////////////////////////////
  // second instance window, short stall limit
  i2c_dma_irq_control #(.BASE_ADDR(BASE), .STALL_LIMIT(50)) DUT (
    .REF_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .SCL_IN(scl),
    .SDA_IN(sda), .ALERT_PIN_IN(alert_n & ~oe), .ALERT_PIN_OUT(alert_o),
    .ALERT_PIN_OE_OUT(oe), .SLAVE_MODE_IN(slave), .TRANSMIT_SET_IN(ev[0]),
    .RECEIVE_FULL_SET_IN(ev[1]), .TX_DATA_WRITTEN_IN(tx_wr), .RX_DATA_READ_IN(rx_rd),
    .ADDRESS_MATCH_SET_IN(ev[2]), .NOT_ACK_SET_IN(ev[3]), .TRANSFER_DONE_SET_IN(ev[4]),
    .TRANSFER_RELOAD_SET_IN(ev[5]), .BUS_FAULT_SET_IN(ev[6]),
    .ARBITRATION_LOST_SET_IN(ev[7]), .OVER_UNDER_SET_IN(ev[8]), .CRC_CLEAR_IN(crc_clr),
    .CRC_BYTE_VALID_IN(crc_v), .PEC_BYTE_VALID_IN(pec_v), .CRC_BYTE_IN(crc_b),
    .ADDR_BYTE_IN(addr_b), .ADDR_ACK_OUT(ack), .DEBUG_HALT_IN(dhalt),
    .DEBUG_HOLD_SELECT_IN(dhold), .DMA_TX_REQ_OUT(tx_req), .DMA_RX_REQ_OUT(rx_req),
    .EVENT_IRQ_OUT(evt), .ERROR_IRQ_OUT(err), .SCL_FILTERED_OUT(sclf),
    .SDA_FILTERED_OUT(sdaf), .MAIN_CONTROL_OUT(mc)
  );
  i2c_remote_model LINK (.scl_out(scl), .sda_out(sda), .alert_out(alert_n));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= BASE + {20'h0, a};
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic clear_flags();
    ahb(1'b1, 12'h008, 32'h0000_3FFC);
    tick(3);
  endtask
  // filter setting is changed with the block off, then enabled
  task automatic set_ctl(input logic [31:0] c);
    ahb(1'b1, 12'h000, c & 32'hFFFF_FFFE);
    ahb(1'b1, 12'h000, c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{32'h0000_4001, 9'h001, 4'h8},
      '{32'h0000_8001, 9'h002, 4'h4},
      '{32'h0000_8001, 9'h001, 4'h0},
      '{32'h0000_4001, 9'h002, 4'h0},
      '{32'h0000_0003, 9'h001, 4'h2},
      '{32'h0000_0005, 9'h002, 4'h2},
      '{32'h0000_0009, 9'h004, 4'h2},
      '{32'h0000_0011, 9'h008, 4'h2},
      '{32'h0000_0041, 9'h010, 4'h2},
      '{32'h0000_0041, 9'h020, 4'h2},
      '{32'h0000_0001, 9'h03F, 4'h0},
      '{32'h0000_0081, 9'h040, 4'h1},
      '{32'h0000_0081, 9'h080, 4'h1},
      '{32'h0000_0081, 9'h100, 4'h1},
      '{32'h0000_C0FE, 9'h1FF, 4'h0}};
    sa = '{7'h61, 7'h08, 7'h00};
    {hsel, hwrite, tx_wr, rx_rd, crc_clr, crc_v, pec_v, slave, dhalt, dhold} = '0;
    {haddr, hwdata, htrans, hsize, ev, crc_b} = '0;
    addr_b = 8'hFF;
    rst = 1'b1;
    tick(2);
    rst <= 1'b0;
    for (i = 0; i < 15; i++) begin
      ahb(1'b1, 12'h000, rows[i].ctrl);
      ev <= rows[i].ev;
      @(posedge clk);
      ev <= 9'h0;
      tick(2);
      chk("irq and dma outputs", {28'h0, rows[i].exp}, {28'h0, outs});
      tx_wr <= 1'b1;
      rx_rd <= 1'b1;
      @(posedge clk);
      tx_wr <= 1'b0;
      rx_rd <= 1'b0;
      clear_flags();
      chk("outputs after service", 32'h0, {28'h0, outs});
    end
    // reset value, reserved bits and an unmapped place
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    chk("outputs after reset", 32'h0000_0003, {24'h0, hresp, alert_o, outs, sclf, sdaf});
    ahb(1'b0, 12'h000, 32'h0);
    chk("control after reset", 32'h0, rd);
    ahb(1'b1, 12'h000, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h000, 32'h0);
    chk("control readback", 32'h00FB_DFFF, rd);
    chk("control port", 32'h00FB_DFFF, mc);
    ahb(1'b0, 12'h00C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    // special address answers follow their enable bits
    for (i = 0; i < 6; i++) begin
      ahb(1'b1, 12'h000, (i % 2) ? 32'h0 : (32'h1 << (21 - i / 2)));
      addr_b <= {sa[i / 2], 1'b0};
      tick(2);
      chk("address ack", {31'h0, i % 2 == 0}, {31'h0, ack});
      addr_b <= 8'hFF;
    end
    // alert pull in device role, alert sensing in host role
    ahb(1'b1, 12'h000, 32'h0040_0000);
    tick(2);
    chk("alert pull", 32'h1, {31'h0, oe});
    ahb(1'b1, 12'h000, 32'h0050_0081);
    dhalt <= 1'b1;
    dhold <= 1'b1;
    tick(5); // own pull released, synchronised line back high first
    LINK.alert(1'b1);
    tick(10);
    chk("alert error", 32'h1, {31'h0, err});
    LINK.alert(1'b0);
    clear_flags();
    chk("alert cleared", 32'h0, {31'h0, err});
    // bus stall count frozen by debug hold, then running to its limit
    ahb(1'b1, 12'h000, 32'h0000_0081);
    LINK.scl_hold(1'b1);
    tick(80);
    chk("filtered clock low", 32'h0, {31'h0, sclf});
    chk("stall frozen", 32'h0, {31'h0, err});
    dhold <= 1'b0;
    tick(60);
    chk("stall error", 32'h1, {31'h0, err});
    LINK.scl_hold(1'b0);
    clear_flags();
    // stop detection through the spike filter
    slave <= 1'b1;
    set_ctl(32'h0000_0221);
    LINK.glitch();
    tick(10);
    chk("spike rejected", 32'h0, {31'h0, evt});
    LINK.frame();
    tick(10);
    chk("stop event", 32'h1, {31'h0, evt});
    clear_flags();
    set_ctl(32'h0000_0021);
    LINK.glitch();
    tick(10);
    chk("spike passed", 32'h1, {31'h0, evt});
    clear_flags();
    // packet checksum of the single byte 01 is 07
    ahb(1'b1, 12'h000, 32'h0080_0081);
    crc_clr <= 1'b1;
    @(posedge clk);
    crc_clr <= 1'b0;
    crc_b <= 8'h01;
    crc_v <= 1'b1;
    @(posedge clk);
    crc_v <= 1'b0;
    for (i = 0; i < 2; i++) begin
      crc_b <= i ? 8'h5A : 8'h07;
      pec_v <= 1'b1;
      @(posedge clk);
      pec_v <= 1'b0;
      tick(3);
      chk("checksum error", i, {31'h0, err});
    end
    ahb(1'b0, 12'h004, 32'h0);
    chk("status word", 32'h0000_0800, rd);
    stop_test();
  end
endmodule
`default_nettype wire
